// file: common/idec_pkg.sv
// Package with opcode, field and size constants for the decode/align block.
package idec_pkg;
    // ==========================================================
    // Instruction fields
    // ==========================================================
    localparam int          INSN_W      = 32;
    localparam int          DATA_W      = 64;
    localparam logic [4:0]  REG_ZERO    = 5'h00;
    localparam logic [4:0]  REG_LINK    = 5'h1F;
    localparam logic [5:0]  OP_SPECIAL  = 6'h00;
    localparam logic [5:0]  OP_REGIMM   = 6'h01;
    localparam logic [5:0]  OP_J        = 6'h02;
    localparam logic [5:0]  OP_JAL      = 6'h03;
    localparam logic [5:0]  OP_BEQ      = 6'h04;
    localparam logic [5:0]  OP_BGTZ     = 6'h07;
    localparam logic [5:0]  OP_COP0     = 6'h10;
    localparam logic [5:0]  OP_COP1     = 6'h11;
    localparam logic [5:0]  OP_COP2     = 6'h12;
    localparam logic [5:0]  OP_BEQL     = 6'h14;
    localparam logic [5:0]  OP_BGTZL    = 6'h17;
    localparam logic [5:0]  OP_LDL      = 6'h1A;
    localparam logic [5:0]  OP_LDR      = 6'h1B;
    localparam logic [5:0]  OP_LB       = 6'h20;
    localparam logic [5:0]  OP_LH       = 6'h21;
    localparam logic [5:0]  OP_LWL      = 6'h22;
    localparam logic [5:0]  OP_LW       = 6'h23;
    localparam logic [5:0]  OP_LBU      = 6'h24;
    localparam logic [5:0]  OP_LHU      = 6'h25;
    localparam logic [5:0]  OP_LWR      = 6'h26;
    localparam logic [5:0]  OP_LWU      = 6'h27;
    localparam logic [5:0]  OP_SB       = 6'h28;
    localparam logic [5:0]  OP_SH       = 6'h29;
    localparam logic [5:0]  OP_SWL      = 6'h2A;
    localparam logic [5:0]  OP_SW       = 6'h2B;
    localparam logic [5:0]  OP_SDL      = 6'h2C;
    localparam logic [5:0]  OP_SDR      = 6'h2D;
    localparam logic [5:0]  OP_SWR      = 6'h2E;
    localparam logic [5:0]  OP_LL       = 6'h30;
    localparam logic [5:0]  OP_LLD      = 6'h34;
    localparam logic [5:0]  OP_LD       = 6'h37;
    localparam logic [5:0]  OP_SC       = 6'h38;
    localparam logic [5:0]  OP_SCD      = 6'h3C;
    localparam logic [5:0]  OP_SD       = 6'h3F;
    localparam logic [5:0]  FN_SLL      = 6'h00;
    localparam logic [5:0]  FN_SRAV     = 6'h07;
    localparam logic [5:0]  FN_JR       = 6'h08;
    localparam logic [5:0]  FN_JALR     = 6'h09;
    localparam logic [5:0]  FN_SYNC     = 6'h0F;
    localparam logic [5:0]  FN_DSLLV    = 6'h14;
    localparam logic [5:0]  FN_DSRAV    = 6'h17;
    localparam logic [5:0]  FN_TGE      = 6'h30;
    localparam logic [5:0]  FN_TNE      = 6'h36;
    localparam logic [5:0]  FN_DSLL     = 6'h38;
    localparam logic [5:0]  FN_DSRA     = 6'h3B;
    localparam logic [5:0]  FN_DWORD_SHL_PLUS_THIRTYTWO   = 6'h3C;
    localparam logic [5:0]  FN_DSRA32   = 6'h3F;
    localparam logic [5:0]  FN_WAIT     = 6'h20;
    localparam logic [4:0]  RT_BLTZ     = 5'h00;
    localparam logic [4:0]  RT_BGEZL    = 5'h03;
    localparam logic [4:0]  RT_TGEI     = 5'h08;
    localparam logic [4:0]  RT_TNEI     = 5'h0E;
    localparam logic [4:0]  RT_BRANCH_NEGATIVE_LINK   = 5'h10;
    localparam logic [4:0]  RT_BGEZALL  = 5'h13;
    localparam logic [4:0]  RS_MF       = 5'h00;
    localparam logic [4:0]  RS_DMF      = 5'h01;
    localparam logic [4:0]  RS_MT       = 5'h04;
    localparam logic [4:0]  RS_DMT      = 5'h05;
    localparam logic [4:0]  RS_BC       = 5'h08;
    localparam logic [5:0]  SHAMT_HI    = 6'h20;

    // ==========================================================
    // Access sizes, system registers
    // ==========================================================
    typedef enum logic [1:0] {
        IDEC_SZ_BYTE  = 2'h0,
        IDEC_SZ_HALF  = 2'h1,
        IDEC_SZ_WORD  = 2'h2,
        IDEC_SZ_DWORD = 2'h3
    } idec_size_t;

    localparam logic [4:0]  SYS_TLB_INDEX  = 5'h00;
    localparam logic [4:0]  SYS_TLB_RANDOM = 5'h01;
    localparam logic [4:0]  SYS_EVEN_LO    = 5'h02;
    localparam logic [4:0]  SYS_ODD_LO     = 5'h03;
    localparam logic [4:0]  SYS_CONTEXT    = 5'h04;
    localparam logic [4:0]  SYS_PAGE_MASK  = 5'h05;
    localparam logic [4:0]  SYS_REG_LAST   = 5'h1F;

    // Power state, Gray coded along run -> standby -> run.
    typedef enum logic [1:0] {
        IDEC_RUN     = 2'b00,
        IDEC_STANDBY = 2'b01
    } idec_pwr_t;
endpackage : idec_pkg

// file: rtl/idec_decode.sv
// Instruction classification, alignment check and endian byte steering.
// ==============================================================
// Overview of operation
// - Byte, half, word, doubleword sizes handled
// - Byte order chosen by configuration input
// - Big-endian: lowest address to top lane
// - Little-endian: lowest address to low lane
// - Bit zero always least significant
// - Halfword aligned only on even address
// - Word aligned only on multiple of four
// - Doubleword aligned only on multiple of eight
// - Left/right partial accesses for misaligned data
// - Misaligned pair costs one extra instruction
// - Wait enters standby only with bus idle
// - Any interrupt leaves standby
// - Reserved system register access is undefined
// - Coprocessor two reserved, no function
// - System register numbers 0 to 5 mapped
// - Pseudorandom pointer register is read only
// - Conditional traps, register or immediate forms
// - Plus-32 doubleword constant shift forms
// - Likely variants of all conditional branches
// - Linked load, conditional store, sync
// - System coprocessor translates, changes privilege
// - Link instructions write general register 31, except JALR which writes rd
// - Register zero reads zero, writes dropped
// - Instruction word is 32 bits wide
// ==============================================================
module idec_decode
    import idec_pkg::*;
#(
    parameter int DW = DATA_W
)
(
    input  wire logic              CORE_CLK,
    input  wire logic              RESETN,
    input  wire logic              CLK_EN,
    input  wire logic              INSN_VALID,
    input  wire logic [INSN_W-1:0] INSN,
    input  wire logic [2:0]        ADDR_LOW,
    input  wire logic [DW-1:0]     STORE_DATA,
    input  wire logic              BIG_ENDIAN,
    input  wire logic              BUS_IDLE,
    input  wire logic              IRQ_ANY,
    output logic                   IS_JUMP,
    output logic                   IS_BRANCH,
    output logic                   IS_LIKELY,
    output logic                   IS_LINK,
    output logic                   IS_TRAP,
    output logic                   IS_SHIFT,
    output logic [5:0]             SHIFT_AMT,
    output logic                   IS_COP_MOVE,
    output logic                   IS_SYS_OP,
    output logic                   IS_LINKED,
    output logic                   IS_SYNC,
    output logic                   IS_MEM,
    output logic                   IS_PARTIAL,
    output logic                   EXTRA_CYCLE,
    output logic [1:0]             MEM_SIZE,
    output logic [7:0]             BYTE_EN,
    output logic [DW-1:0]          LANE_DATA,
    output logic                   ADDR_ERROR,
    output logic                   RESERVED_INSN,
    output logic                   SYS_REG_WRITE,
    output logic                   SYS_REG_UNDEF,
    output logic [4:0]             DEST_REG,
    output logic                   DEST_WRITE,
    output logic                   STANDBY
);

    // ==========================================================
    // Reset release
    // ==========================================================
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge CORE_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ==========================================================
    // Field decode
    // ==========================================================
    logic [5:0] op;
    logic [5:0] fn;
    logic [4:0] rs;
    logic [4:0] rt;
    logic [4:0] rd;
    logic [4:0] sa;
    assign op = INSN[31:26];
    assign rs = INSN[25:21];
    assign rt = INSN[20:16];
    assign rd = INSN[15:11];
    assign sa = INSN[10:6];
    assign fn = INSN[5:0];

    logic       special;
    logic       regimm;
    logic       cop_any;
    logic       jump;
    logic       br_norm;
    logic       br_likely;
    logic       br_cop;
    logic       link;
    logic       trap;
    logic       shift;
    logic [5:0] shamt;
    logic       partial;
    logic       linked;
    logic       mem;
    logic       store;
    logic       wait_op;
    logic [1:0] size;
    logic       misal;

    always_comb
    begin
        special = (op == OP_SPECIAL);
        regimm  = (op == OP_REGIMM);
        cop_any = (op == OP_COP0) || (op == OP_COP1) || (op == OP_COP2);
        jump    = (op == OP_J) || (op == OP_JAL)
                  || (special && (fn == FN_JR || fn == FN_JALR));
        br_cop  = cop_any && (rs == RS_BC);
        // Likely branches sit in their own opcode rows or rt codes.
        br_likely = (op >= OP_BEQL && op <= OP_BGTZL)
                    || (regimm && rt[1] && !rt[3])
                    || (br_cop && rt[1]);
        br_norm = (op >= OP_BEQ && op <= OP_BGTZ)
                  || (regimm && (rt <= RT_BGEZL
                      || (rt >= RT_BRANCH_NEGATIVE_LINK && rt <= RT_BGEZALL)))
                  || br_likely || br_cop;
        link    = (op == OP_JAL) || (special && fn == FN_JALR)
                  || (regimm && rt >= RT_BRANCH_NEGATIVE_LINK && rt <= RT_BGEZALL);
        trap    = (special && fn >= FN_TGE && fn <= FN_TNE)
                  || (regimm && rt >= RT_TGEI && rt <= RT_TNEI);
        shift   = special && (fn <= FN_SRAV
                  || (fn >= FN_DSLLV && fn <= FN_DSRAV)
                  || fn >= FN_DSLL);
        shamt   = {1'b0, sa};
        if (special && fn >= FN_DWORD_SHL_PLUS_THIRTYTWO && fn <= FN_DSRA32)
            shamt = {1'b0, sa} + SHAMT_HI;
        partial = (op == OP_LWL) || (op == OP_LWR) || (op == OP_SWL)
                  || (op == OP_SWR) || (op == OP_LDL) || (op == OP_LDR)
                  || (op == OP_SDL) || (op == OP_SDR);
        linked  = (op == OP_LL) || (op == OP_LLD)
                  || (op == OP_SC) || (op == OP_SCD);
        mem     = (op >= OP_LB && op <= OP_SD && op != 6'h2F
                   && op != 6'h33 && op != 6'h3B)
                  || op == OP_LDL || op == OP_LDR;
        // Doubleword left/right loads also carry opcode bit 3.
        store   = op[3] && (op >= OP_SB);
        wait_op = (op == OP_COP0) && rs[4] && (fn == FN_WAIT);
        case (op)
            OP_LB, OP_LBU, OP_SB:             size = IDEC_SZ_BYTE;
            OP_LH, OP_LHU, OP_SH:             size = IDEC_SZ_HALF;
            OP_LW, OP_LWU, OP_SW, OP_LL, OP_SC,
            OP_LWL, OP_LWR, OP_SWL, OP_SWR:   size = IDEC_SZ_WORD;
            default:                          size = IDEC_SZ_DWORD;
        endcase
        case (size)
            IDEC_SZ_HALF:  misal = ADDR_LOW[0];
            IDEC_SZ_WORD:  misal = |ADDR_LOW[1:0];
            IDEC_SZ_DWORD: misal = |ADDR_LOW;
            default:       misal = 1'b0;
        endcase
    end

    // ==========================================================
    // Byte lane steering
    // ==========================================================
    // A lane index counts address bytes; big-endian mirrors it so the
    // lowest address lands in the top lane. Bit 0 stays the LSB.
    logic [7:0]    next_be;
    logic [DW-1:0] next_lane;
    logic [3:0]    nbytes;
    assign nbytes = 4'h1 << size;

    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : g_lane
            logic [2:0] off;
            logic [3:0] src;
            logic       in_op;
            assign off   = 3'(g) - ADDR_LOW;
            assign in_op = ({1'b0, off} < nbytes) && (3'(g) >= ADDR_LOW);
            // Big-endian: lane base+n-1-k takes operand byte k.
            assign src   = BIG_ENDIAN ? (nbytes - 4'h1 - 4'(off))
                                      : 4'(off);
            assign next_be[g] = in_op;
            assign next_lane[g*8 +: 8] =
                in_op ? STORE_DATA[8*src +: 8] : 8'h00;
        end
    endgenerate

    // ==========================================================
    // Registered outputs
    // ==========================================================
    logic extra_pend;
    always_ff @(posedge CORE_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            IS_JUMP       <= 1'b0;
            IS_BRANCH     <= 1'b0;
            IS_LIKELY     <= 1'b0;
            IS_LINK       <= 1'b0;
            IS_TRAP       <= 1'b0;
            IS_SHIFT      <= 1'b0;
            SHIFT_AMT     <= 6'h00;
            IS_COP_MOVE   <= 1'b0;
            IS_SYS_OP     <= 1'b0;
            IS_LINKED     <= 1'b0;
            IS_SYNC       <= 1'b0;
            IS_MEM        <= 1'b0;
            IS_PARTIAL    <= 1'b0;
            MEM_SIZE      <= 2'h0;
            BYTE_EN       <= 8'h00;
            LANE_DATA     <= '0;
            ADDR_ERROR    <= 1'b0;
            RESERVED_INSN <= 1'b0;
            SYS_REG_WRITE <= 1'b0;
            SYS_REG_UNDEF <= 1'b0;
            DEST_REG      <= 5'h00;
            DEST_WRITE    <= 1'b0;
        end
        else if (CLK_EN)
        begin
            IS_JUMP     <= INSN_VALID && jump;
            IS_BRANCH   <= INSN_VALID && br_norm && (op != OP_COP2);
            IS_LIKELY   <= INSN_VALID && br_likely && (op != OP_COP2);
            IS_LINK     <= INSN_VALID && link;
            IS_TRAP     <= INSN_VALID && trap;
            IS_SHIFT    <= INSN_VALID && shift;
            SHIFT_AMT   <= shamt;
            IS_COP_MOVE <= INSN_VALID && cop_any && (op != OP_COP2)
                           && (rs == RS_MF || rs == RS_DMF
                               || rs == RS_MT || rs == RS_DMT);
            // TLB and mode-change operations go to the system unit.
            IS_SYS_OP   <= INSN_VALID && (op == OP_COP0);
            IS_LINKED   <= INSN_VALID && linked;
            IS_SYNC     <= INSN_VALID && special && (fn == FN_SYNC);
            IS_MEM      <= INSN_VALID && mem;
            IS_PARTIAL  <= INSN_VALID && partial;
            MEM_SIZE    <= size;
            BYTE_EN     <= (INSN_VALID && mem && !misal) ? next_be : 8'h00;
            LANE_DATA   <= next_lane;
            // Partial forms exist to reach misaligned data and never trap.
            ADDR_ERROR  <= INSN_VALID && mem && !partial && misal;
            RESERVED_INSN <= INSN_VALID && (op == OP_COP2);
            // Writes to the pseudorandom pointer are suppressed.
            SYS_REG_WRITE <= INSN_VALID && (op == OP_COP0)
                             && (rs == RS_MT || rs == RS_DMT)
                             && (rd != SYS_TLB_RANDOM);
            // Only 0..5 are decoded here; other numbers are flagged for MF and MT moves, not DMF or DMT.
            SYS_REG_UNDEF <= INSN_VALID && (op == OP_COP0)
                             && (rs == RS_MF || rs == RS_MT)
                             && (rd > SYS_PAGE_MASK);
            DEST_REG    <= link && (op != OP_SPECIAL) ? REG_LINK
                           : (special ? rd : rt);
            DEST_WRITE  <= INSN_VALID && (link || special || (mem && !store))
                           && ((link && op != OP_SPECIAL)
                               || (special ? rd : rt) != REG_ZERO);
        end
    end

    // Second half of a left/right pair is the one extra instruction.
    always_ff @(posedge CORE_CLK or negedge rst_n)
    begin
        if (!rst_n)
            extra_pend <= 1'b0;
        else if (CLK_EN && INSN_VALID)
            extra_pend <= partial && !extra_pend;
    end
    assign EXTRA_CYCLE = extra_pend;

    // ==========================================================
    // Standby control
    // ==========================================================
    idec_pwr_t pwr;
    always_ff @(posedge CORE_CLK or negedge rst_n)
    begin
        if (!rst_n)
            pwr <= IDEC_RUN;
        else if (CLK_EN)
            case (pwr)
                IDEC_RUN:
                    if (INSN_VALID && wait_op && BUS_IDLE)
                        pwr <= IDEC_STANDBY;
                IDEC_STANDBY:
                    if (IRQ_ANY)
                        pwr <= IDEC_RUN;
                default: pwr <= IDEC_RUN;
            endcase
    end
    assign STANDBY = (pwr == IDEC_STANDBY);

    // ==========================================================
    // Checks
    // ==========================================================
    chk_standby_entry: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        CLK_EN && INSN_VALID && wait_op && !BUS_IDLE && !STANDBY
        |=> !STANDBY) else $error("standby entered with bus busy");
    chk_standby_exit: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        CLK_EN && STANDBY && IRQ_ANY |=> !STANDBY)
        else $error("interrupt did not end standby");
    chk_half_align: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        CLK_EN && INSN_VALID && (op == OP_LH || op == OP_SH) && ADDR_LOW[0]
        |=> ADDR_ERROR && BYTE_EN == 8'h00)
        else $error("odd halfword not flagged");
    chk_word_align: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        CLK_EN && INSN_VALID && (op == OP_LW || op == OP_SW)
        && ADDR_LOW[1:0] == 2'h2
        |=> ADDR_ERROR) else $error("misaligned word not flagged");
    chk_dword_align: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        CLK_EN && INSN_VALID && (op == OP_LD || op == OP_SD)
        && ADDR_LOW == 3'h0
        |=> !ADDR_ERROR && BYTE_EN == 8'hFF)
        else $error("aligned dword refused");
    chk_partial_ok: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        CLK_EN && INSN_VALID && op == OP_LWL |=> !ADDR_ERROR && IS_PARTIAL)
        else $error("partial access trapped");
    chk_link_dest: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        CLK_EN && INSN_VALID && op == OP_JAL
        |=> DEST_REG == REG_LINK && DEST_WRITE)
        else $error("link not to r31");
    chk_zero_drop: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        DEST_WRITE |-> DEST_REG != REG_ZERO)
        else $error("write to register zero");
    chk_random_ro: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        CLK_EN && INSN_VALID && op == OP_COP0 && rs == RS_MT
        && rd == SYS_TLB_RANDOM |=> !SYS_REG_WRITE)
        else $error("random pointer written");
    chk_shift_plus: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        CLK_EN && special && fn == FN_DWORD_SHL_PLUS_THIRTYTWO
        |=> SHIFT_AMT == 6'(SHAMT_HI + $past(sa)) && SHIFT_AMT[5])
        else $error("plus-32 shift lost");

endmodule // idec_decode

// file: verif/idec_pipe_model.sv
// Behavioural model of the pipeline side: bus activity and interrupts.
// ==========================================================
// Pipeline partner
// ==========================================================
module idec_pipe_model
(
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic       busy_cmd,
    input  wire logic [3:0] busy_len,
    input  wire logic       irq_cmd,
    output logic            bus_idle,
    output logic            irq_any
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] busy_cnt;
    // A transfer holds the bus for busy_len cycles, so both a quick and a
    // slow bus can be shown to the core.
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            busy_cnt <= 4'h0;
        else if (busy_cmd)
            busy_cnt <= busy_len;
        else if (busy_cnt != 4'h0)
            busy_cnt <= busy_cnt - 4'h1;
    end
    assign bus_idle = (busy_cnt == 4'h0);
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            irq_any <= 1'b0;
        else
            irq_any <= irq_cmd;
    end
endmodule // idec_pipe_model

// file: verif/tb_top.sv
// Self-checking testbench for the decode, alignment and steering block.
// ==========================================================
// Bench top
// ==========================================================
module tb_top
    import idec_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic CORE_CLK, RESETN, CLK_EN, INSN_VALID, BIG_ENDIAN, BUS_IDLE, IRQ_ANY;
    logic [31:0] INSN;
    logic [2:0]  ADDR_LOW;
    logic [63:0] STORE_DATA, LANE_DATA;
    logic IS_JUMP, IS_BRANCH, IS_LIKELY, IS_LINK, IS_TRAP, IS_SHIFT, IS_SYNC;
    logic IS_COP_MOVE, IS_SYS_OP, IS_LINKED, IS_MEM, IS_PARTIAL, EXTRA_CYCLE;
    logic ADDR_ERROR, RESERVED_INSN, SYS_REG_WRITE, SYS_REG_UNDEF, DEST_WRITE;
    logic STANDBY, busy_cmd, irq_cmd;
    logic [5:0]  SHIFT_AMT;
    logic [1:0]  MEM_SIZE;
    logic [7:0]  BYTE_EN;
    logic [4:0]  DEST_REG;
    logic [3:0]  busy_len;
    int          err_total, n_checks, cycles;
    idec_decode dut (.CORE_CLK, .RESETN, .CLK_EN, .INSN_VALID, .INSN,
        .ADDR_LOW, .STORE_DATA, .BIG_ENDIAN, .BUS_IDLE, .IRQ_ANY, .IS_JUMP,
        .IS_BRANCH, .IS_LIKELY, .IS_LINK, .IS_TRAP, .IS_SHIFT, .SHIFT_AMT,
        .IS_COP_MOVE, .IS_SYS_OP, .IS_LINKED, .IS_SYNC, .IS_MEM, .IS_PARTIAL,
        .EXTRA_CYCLE, .MEM_SIZE, .BYTE_EN, .LANE_DATA, .ADDR_ERROR,
        .RESERVED_INSN, .SYS_REG_WRITE, .SYS_REG_UNDEF, .DEST_REG,
        .DEST_WRITE, .STANDBY);
    idec_pipe_model partner (.core_clk(CORE_CLK), .resetn(RESETN),
        .busy_cmd(busy_cmd), .busy_len(busy_len), .irq_cmd(irq_cmd),
        .bus_idle(BUS_IDLE), .irq_any(IRQ_ANY));
    initial
    begin
        CORE_CLK = 1'b0;
        forever #2.5 CORE_CLK = ~CORE_CLK;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // The ceiling is far above the roughly 120 cycles the run needs.
    always @(posedge CORE_CLK)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_total++;
            end_sim();
        end
    end
    task automatic chk_vec(input logic [63:0] got, exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, exp, input string what);
        chk_vec({63'h0, got}, {63'h0, exp}, what);
    endtask
    // Inputs change at the falling edge; results are read one cycle later.
    task automatic issue(input logic [31:0] i, input logic [2:0] a);
        INSN = i;
        ADDR_LOW = a;
        INSN_VALID = 1'b1;
        @(posedge CORE_CLK);
        @(negedge CORE_CLK);
    endtask
    task automatic dec(input logic [31:0] i, input logic [10:0] exp, care);
        // Flag order: jump branch likely link trap shift linked sync mem
        // partial reserved.
        issue(i, 3'h0);
        chk_vec({53'h0, {IS_JUMP, IS_BRANCH, IS_LIKELY, IS_LINK, IS_TRAP,
            IS_SHIFT, IS_LINKED, IS_SYNC, IS_MEM, IS_PARTIAL, RESERVED_INSN}
            & care}, {53'h0, exp & care}, "class");
    endtask
    task automatic t_classes();
        dec({OP_JAL, 26'h0}, 11'h480, 11'h7FF);
        chk_vec({59'h0, DEST_WRITE, DEST_REG}, {59'h0, 1'b1, REG_LINK}, "jal");
        dec({OP_J, 26'h0}, 11'h400, 11'h7FF);
        dec({OP_SPECIAL, 10'h0, REG_LINK, 5'h0, FN_JALR}, 11'h480, 11'h7FF);
        dec({OP_BEQ, 26'h0}, 11'h200, 11'h7FF);
        dec({OP_BEQL, 26'h0}, 11'h300, 11'h7FF);
        dec({OP_BGTZL, 26'h0}, 11'h300, 11'h7FF);
        dec({OP_REGIMM, 5'h0, RT_BRANCH_NEGATIVE_LINK, 16'h0}, 11'h280, 11'h7FF);
        dec({OP_REGIMM, 5'h0, RT_BGEZALL, 16'h0}, 11'h380, 11'h7FF);
        chk_vec({59'h0, DEST_WRITE, DEST_REG}, {59'h0, 1'b1, REG_LINK}, "bal");
        dec({OP_COP1, RS_BC, 5'h03, 16'h0}, 11'h300, 11'h7FF);
        dec({OP_COP0, RS_BC, 5'h02, 16'h0}, 11'h300, 11'h7FF);
        dec({OP_SPECIAL, 20'h0, FN_TNE}, 11'h040, 11'h7FF);
        dec({OP_SPECIAL, 20'h0, FN_TGE}, 11'h040, 11'h7FF);
        dec({OP_REGIMM, 5'h0, RT_TGEI, 16'h0}, 11'h040, 11'h7FF);
        dec({OP_REGIMM, 5'h0, RT_TNEI, 16'h0}, 11'h040, 11'h7FF);
        dec({OP_LL, 26'h0}, 11'h010, 11'h7FB);
        dec({OP_SCD, 26'h0}, 11'h010, 11'h7FB);
        dec({OP_SPECIAL, 20'h0, FN_SYNC}, 11'h008, 11'h7FF);
        dec({OP_COP2, 26'h0}, 11'h001, 11'h7FF);
        dec({OP_SPECIAL, 10'h0, REG_ZERO, 5'h0, 6'h21}, 11'h000, 11'h7FF);
        chk_bit(DEST_WRITE, 1'b0, "r0 write");
        issue({OP_SPECIAL, 15'h0, 5'h05, FN_DWORD_SHL_PLUS_THIRTYTWO}, 3'h0);
        chk_vec({58'h0, SHIFT_AMT}, 64'h25, "dword_shl_plus_thirtytwo");
        issue({OP_SPECIAL, 15'h0, 5'h00, FN_DSRA32}, 3'h0);
        chk_vec({57'h0, IS_SHIFT, SHIFT_AMT}, 64'h60, "dsra32");
        issue({OP_SPECIAL, 15'h0, 5'h05, FN_DSLL}, 3'h0);
        chk_vec({58'h0, SHIFT_AMT}, 64'h05, "dsll");
        CLK_EN = 1'b0;
        issue({OP_J, 26'h0}, 3'h0);
        chk_vec({57'h0, IS_JUMP, SHIFT_AMT}, 64'h05, "frozen");
        CLK_EN = 1'b1;
    endtask
    task automatic t_sysreg();
        for (int r = 0; r < 8; r++)
        begin
            issue({OP_COP0, RS_MT, 5'h01, r[4:0], 11'h0}, 3'h0);
            chk_bit(IS_COP_MOVE, 1'b1, "cop move");
            chk_bit(SYS_REG_WRITE, r != 1, "sys write");
            chk_bit(SYS_REG_UNDEF, r > 5, "sys undef");
        end
    endtask
    // Byte k of the operand lands on lane a+k, or a+n-1-k in big-endian.
    function automatic logic [63:0] steer(input int n, a, input logic big,
        input logic [63:0] d);
        logic [63:0] r;
        r = 64'h0;
        for (int k = 0; k < n; k++)
            r[8*(big ? a+n-1-k : a+k) +: 8] = d[8*k +: 8];
        return r;
    endfunction
    task automatic t_align();
        logic [5:0]  ops [4];
        logic [63:0] m;
        int          n;
        ops = '{OP_SB, OP_SH, OP_SW, OP_SD};
        for (int b = 0; b < 2; b++)
            for (int s = 0; s < 4; s++)
                for (int a = 0; a < 8; a++)
                begin
                    BIG_ENDIAN = b[0];
                    STORE_DATA = 64'h8877665544332211 ^ {8{a[7:0]}};
                    n = 1 << s;
                    m = (a % n == 0) ? steer(n, a, 1'b0, {64{1'b1}}) : 64'h0;
                    issue({ops[s], 26'h0}, a[2:0]);
                    chk_bit(ADDR_ERROR, a % n != 0, "addr error");
                    chk_vec({56'h0, BYTE_EN}, {56'h0, m[56], m[48], m[40],
                        m[32], m[24], m[16], m[8], m[0]}, "byte en");
                    chk_vec({62'h0, MEM_SIZE}, s, "size");
                    chk_vec(LANE_DATA & m, steer(n, a, b[0], STORE_DATA) & m,
                        "lanes");
                end
    endtask
    task automatic t_partial();
        logic [5:0] left [4];
        logic [5:0] right [4];
        left = '{OP_LWL, OP_SWL, OP_LDL, OP_SDL};
        right = '{OP_LWR, OP_SWR, OP_LDR, OP_SDR};
        for (int p = 0; p < 4; p++)
        begin
            issue({left[p], 26'h0}, 3'h3);
            chk_vec({62'h0, IS_PARTIAL, EXTRA_CYCLE}, 64'h3, "left");
            chk_bit(ADDR_ERROR, 1'b0, "left err");
            issue({right[p], 26'h0}, 3'h3);
            chk_vec({62'h0, IS_PARTIAL, EXTRA_CYCLE}, 64'h2, "right");
        end
    endtask
    task automatic t_standby();
        busy_cmd = 1'b1;
        @(negedge CORE_CLK);
        busy_cmd = 1'b0;
        issue({OP_COP0, 5'h10, 15'h0, FN_WAIT}, 3'h0);
        chk_bit(STANDBY, 1'b0, "busy wait");
        for (int w = 0; w < 20 && BUS_IDLE !== 1'b1; w++)
            @(negedge CORE_CLK);
        issue({OP_COP0, 5'h10, 15'h0, FN_WAIT}, 3'h0);
        INSN_VALID = 1'b0;
        chk_bit(STANDBY, 1'b1, "enter");
        repeat (3) @(negedge CORE_CLK);
        irq_cmd = 1'b1;
        @(negedge CORE_CLK);
        chk_bit(STANDBY, 1'b1, "hold");
        @(negedge CORE_CLK);
        chk_bit(STANDBY, 1'b0, "wake");
        irq_cmd = 1'b0;
    endtask
    initial
    begin
        {RESETN, INSN_VALID, BIG_ENDIAN, busy_cmd, irq_cmd} = 5'h0;
        {CLK_EN, INSN, ADDR_LOW, STORE_DATA} = {1'b1, 99'h0};
        busy_len = 4'h4;
        {err_total, n_checks, cycles} = {32'h0, 32'h0, 32'h0};
        repeat (4) @(posedge CORE_CLK);
        @(negedge CORE_CLK);
        RESETN = 1'b1;
        repeat (3) @(negedge CORE_CLK);
        t_classes();
        t_sysreg();
        t_align();
        t_partial();
        t_standby();
        end_sim();
    end
endmodule // tb_top
